/* rtl/wsf_pkg.sv */
// Shared constants and types for the weight status frame encoder.
// Assumes one 40 MHz clock domain; no register bus, all controls are ports.
package wsf_pkg;

  // Framing characters
  localparam logic [7:0] WSF_ASCII_STX  = 8'h02;
  localparam logic [7:0] WSF_ASCII_CR   = 8'h0D;
  localparam logic [7:0] WSF_ASCII_ZERO = 8'h30;

  // Telegram layout: byte index of each field
  localparam int         WSF_DIGITS     = 7;
  localparam int         WSF_IDX_W      = 5;
  localparam logic [4:0] WSF_IDX_STX    = 5'h00;
  localparam logic [4:0] WSF_IDX_STA    = 5'h01;
  localparam logic [4:0] WSF_IDX_STB    = 5'h02;
  localparam logic [4:0] WSF_IDX_STC    = 5'h03;
  localparam logic [4:0] WSF_IDX_GROSS  = 5'h04;
  localparam logic [4:0] WSF_IDX_TARE   = 5'h0B;
  localparam logic [4:0] WSF_IDX_CR     = 5'h12;
  localparam logic [2:0] WSF_DIGIT_MSD  = 3'h6;

  // Fixed status bit values
  localparam logic       WSF_BIT_ONE    = 1'b1;
  localparam logic       WSF_BIT_UNUSED = 1'b0;
  localparam logic [7:0] WSF_STC_VALUE  = 8'hFF;

  // Decimal point codes carried in status byte A bits 2..0
  localparam logic [2:0] WSF_DP_TRAIL00 = 3'h0;
  localparam logic [2:0] WSF_DP_1       = 3'h3;
  localparam logic [2:0] WSF_DP_2       = 3'h4;
  localparam logic [2:0] WSF_DP_3       = 3'h5;
  localparam logic [2:0] WSF_DP_4       = 3'h6;
  localparam logic [2:0] WSF_DP_5       = 3'h7;

  // Step codes carried in status byte A bits 4..3 (bit4 is the msb)
  localparam logic [1:0] WSF_RD_STEP1   = 2'h1;
  localparam logic [1:0] WSF_RD_STEP2   = 2'h2;
  localparam logic [1:0] WSF_RD_STEP5   = 2'h3;

  // Requested decimal places from the scale configuration
  typedef enum logic [2:0] {
    WSF_DEC_TRAIL00 = 3'h0,
    WSF_DEC_1       = 3'h1,
    WSF_DEC_2       = 3'h2,
    WSF_DEC_3       = 3'h3,
    WSF_DEC_4       = 3'h4,
    WSF_DEC_5       = 3'h5
  } wsf_dec_e;

  // Requested display step; the fourth code is reserved
  typedef enum logic [1:0] {
    WSF_STEP_1 = 2'h0,
    WSF_STEP_2 = 2'h1,
    WSF_STEP_5 = 2'h2
  } wsf_step_e;

  // Output format selector values
  localparam logic [2:0] WSF_FMT_RESET = 3'h2;
  localparam logic [2:0] WSF_FMT_MAX   = 3'h4;
  localparam logic [2:0] WSF_FMT_CONT  = 3'h4;

  // Baud rate choices
  typedef enum logic [2:0] {
    WSF_BAUD_1200  = 3'h0,
    WSF_BAUD_2400  = 3'h1,
    WSF_BAUD_4800  = 3'h2,
    WSF_BAUD_9600  = 3'h3,
    WSF_BAUD_19200 = 3'h4
  } wsf_baud_e;
  localparam int WSF_RATE_1200  = 1200;
  localparam int WSF_RATE_2400  = 2400;
  localparam int WSF_RATE_4800  = 4800;
  localparam int WSF_RATE_9600  = 9600;
  localparam int WSF_RATE_19200 = 19200;
  localparam int WSF_DIV_W      = 16;
  localparam int WSF_CHAR_BITS  = 9;  // Data bits plus stop after the start bit

  // Framer states, Gray coded along idle, send, wait
  typedef enum logic [1:0] {
    WSF_ST_IDLE = 2'b00,
    WSF_ST_SEND = 2'b01,
    WSF_ST_WAIT = 2'b11
  } wsf_state_e;

  // Measurement flags from the weighing core
  typedef struct packed {
    logic net;
    logic negative;
    logic overload;
    logic motion;
    logic kg;
    logic pu_zeroed;
  } wsf_meas_s;

  // Scale display configuration
  typedef struct packed {
    wsf_dec_e  dec;
    logic [1:0] step;
  } wsf_scale_cfg_s;

  // Status byte A layout, bit 7 first
  typedef struct packed {
    logic       unused7;
    logic       one6;
    logic       one5;
    logic [1:0] step;
    logic [2:0] dp;
  } wsf_status_a_s;

  // Status byte B layout, bit 7 first
  typedef struct packed {
    logic unused7;
    logic pu_zeroed;
    logic one5;
    logic kg;
    logic motion;
    logic overload;
    logic negative;
    logic net;
  } wsf_status_b_s;

  typedef logic [WSF_DIGITS-1:0][3:0] wsf_digits_t;

  // Bit period in clock cycles, rounded down, at least one
  function automatic logic [WSF_DIV_W-1:0] wsf_bit_cycles(input int clk_hz, input int rate);
    int cyc;
    cyc = clk_hz / rate;
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return WSF_DIV_W'(cyc);
  endfunction : wsf_bit_cycles

endpackage : wsf_pkg

/* rtl/wsf_status_encoder.sv */
// Combinational encoder for the three status bytes of the telegram.
// Assumes its inputs are already registered on the system clock.
`timescale 1ns/10ps
module wsf_status_encoder
  import wsf_pkg::*;
(
  // Scale state
  input  wire wsf_scale_cfg_s cfg_in,
  input  wire wsf_meas_s      meas_in,
  // Encoded bytes
  output wsf_status_a_s       status_a_out,
  output wsf_status_b_s       status_b_out,
  output logic [7:0]          status_c_out
);

  logic       dec_ok;
  logic       step_ok;
  logic       cfg_ok;
  logic [2:0] dp_code;
  logic [1:0] rd_code;

  // Reserved settings force the plain no-decimal, step-one encoding
  assign dec_ok  = (cfg_in.dec <= WSF_DEC_5);
  assign step_ok = (cfg_in.step != 2'h3);
  assign cfg_ok  = dec_ok && step_ok;

  // Decimal code lookup
  assign dp_code = !cfg_ok                  ? WSF_DP_TRAIL00 :
                   (cfg_in.dec == WSF_DEC_1) ? WSF_DP_1 :
                   (cfg_in.dec == WSF_DEC_2) ? WSF_DP_2 :
                   (cfg_in.dec == WSF_DEC_3) ? WSF_DP_3 :
                   (cfg_in.dec == WSF_DEC_4) ? WSF_DP_4 :
                   (cfg_in.dec == WSF_DEC_5) ? WSF_DP_5 :
                   WSF_DP_TRAIL00;

  // Readability code lookup; code 00 is never produced
  assign rd_code = !cfg_ok                    ? WSF_RD_STEP1 :
                   (cfg_in.step == WSF_STEP_2) ? WSF_RD_STEP2 :
                   (cfg_in.step == WSF_STEP_5) ? WSF_RD_STEP5 :
                   WSF_RD_STEP1;

  // Byte A
  assign status_a_out.dp      = dp_code;
  assign status_a_out.step    = rd_code;
  assign status_a_out.one5    = WSF_BIT_ONE;
  assign status_a_out.one6    = WSF_BIT_ONE;
  assign status_a_out.unused7 = WSF_BIT_UNUSED;

  // Byte B
  assign status_b_out.net       = meas_in.net;
  assign status_b_out.negative  = meas_in.negative;
  assign status_b_out.overload  = meas_in.overload;
  assign status_b_out.motion    = meas_in.motion;
  assign status_b_out.kg        = meas_in.kg;
  assign status_b_out.one5      = WSF_BIT_ONE;
  assign status_b_out.pu_zeroed = meas_in.pu_zeroed;
  assign status_b_out.unused7   = WSF_BIT_UNUSED;

  // Byte C carries no information
  assign status_c_out = WSF_STC_VALUE;

endmodule : wsf_status_encoder

/* rtl/wsf_uart_tx.sv */
// Serial character transmitter: start bit, eight data bits LSB first, stop bit.
// Assumes the bit period is given in clock cycles and held per character.
`timescale 1ns/10ps
module wsf_uart_tx
  import wsf_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  // Character input
  input  wire logic                 valid_in,
  input  wire logic [7:0]           data_in,
  input  wire logic [WSF_DIV_W-1:0] bit_cycles_in,
  output logic                      ready_out,
  // Serial line
  output logic                      txd_out
);

  logic                 busy_q;
  logic                 txd_q;
  logic [8:0]           shift_q;
  logic [3:0]           bits_q;
  logic [WSF_DIV_W-1:0] baud_q;
  logic [WSF_DIV_W-1:0] period_q;
  logic                 accept;
  logic                 tick;
  logic                 last;

  assign ready_out = !busy_q;
  assign accept    = valid_in && !busy_q;
  assign tick      = busy_q && (baud_q == '0);
  assign last      = (bits_q == 4'h0);
  assign txd_out   = txd_q;

  // Period is latched per character so a baud change never tears a character
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      busy_q   <= 1'b0;
      txd_q    <= 1'b1;
      shift_q  <= '0;
      bits_q   <= '0;
      baud_q   <= '0;
      period_q <= '0;
    end
    else if (accept)
    begin
      busy_q   <= 1'b1;
      txd_q    <= 1'b0;
      shift_q  <= {1'b1, data_in};
      bits_q   <= 4'(WSF_CHAR_BITS);
      baud_q   <= bit_cycles_in - 1'b1;
      period_q <= bit_cycles_in;
    end
    else if (tick)
    begin
      if (last)
      begin
        busy_q <= 1'b0;                                // Stop bit done
      end
      else
      begin
        txd_q   <= shift_q[0];
        shift_q <= {1'b1, shift_q[8:1]};
        bits_q  <= bits_q - 1'b1;
        baud_q  <= period_q - 1'b1;
      end
    end
    else if (busy_q)
    begin
      baud_q <= baud_q - 1'b1;
    end
  end

endmodule : wsf_uart_tx

/* rtl/wsf_frame_encoder.sv */
// Continuous weight telegram framer with status byte encoding and serial output.
// Assumes all inputs come from logic on clk_in; the only pin is the serial line.
// Formats 0..3 are accepted but keep the line idle; only format 4 is built.
// Bit periods are whole clock cycles, so a rate that does not divide rounds down.
`timescale 1ns/10ps
module wsf_frame_encoder
  import wsf_pkg::*;
#(
  parameter int CLK_HZ = 40000000
)
(
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            reset_n_in,
  // Measurement
  input  wire wsf_meas_s       meas_in,
  input  wire wsf_scale_cfg_s  scale_cfg_in,
  input  wire wsf_digits_t     gross_bcd_in,
  input  wire wsf_digits_t     tare_bcd_in,
  // Configuration
  input  wire wsf_baud_e       baud_sel_in,
  input  wire logic            fmt_wr_in,
  input  wire logic [2:0]      fmt_data_in,
  output logic [2:0]           output_format_selector_out,
  // Status
  output logic                 telegram_active_out,
  output logic                 telegram_start_out,
  output logic [7:0]           status_byte_first_out,
  output logic [7:0]           status_byte_second_out,
  output logic [7:0]           status_byte_third_out,
  // Serial line
  output logic                 txd_out
);

  // Bit periods for each baud choice, worked out at elaboration
  // so no divider has to run in hardware
  localparam logic [WSF_DIV_W-1:0] DIV_1200  = wsf_bit_cycles(CLK_HZ, WSF_RATE_1200);
  localparam logic [WSF_DIV_W-1:0] DIV_2400  = wsf_bit_cycles(CLK_HZ, WSF_RATE_2400);
  localparam logic [WSF_DIV_W-1:0] DIV_4800  = wsf_bit_cycles(CLK_HZ, WSF_RATE_4800);
  localparam logic [WSF_DIV_W-1:0] DIV_9600  = wsf_bit_cycles(CLK_HZ, WSF_RATE_9600);
  localparam logic [WSF_DIV_W-1:0] DIV_19200 = wsf_bit_cycles(CLK_HZ, WSF_RATE_19200);

  // Registers
  wsf_state_e           state_q;
  wsf_state_e           state_d;
  logic [2:0]           fmt_q;
  logic [WSF_IDX_W-1:0] idx_q;
  logic [WSF_IDX_W-1:0] idx_d;
  wsf_status_a_s        sta_q;
  wsf_status_b_s        stb_q;
  logic [7:0]           stc_q;
  wsf_digits_t          gross_q;
  wsf_digits_t          tare_q;
  logic [WSF_DIV_W-1:0] period_q;
  logic                 start_q;

  // Decodes
  wsf_status_a_s        sta_now;
  wsf_status_b_s        stb_now;
  logic [7:0]           stc_now;
  logic [WSF_DIV_W-1:0] period_sel;
  logic                 fmt_legal;
  logic                 continuous;
  logic                 tx_valid;
  logic                 tx_ready;
  logic                 at_last;
  logic                 begin_frame;
  logic [WSF_IDX_W-1:0] gross_ofs;
  logic [WSF_IDX_W-1:0] tare_ofs;
  logic [3:0]           gross_digit;
  logic [3:0]           tare_digit;
  logic                 in_gross;
  logic                 in_tare;
  logic [7:0]           tx_byte;

  // Named decodes keep the processes short
  logic                 in_idle;
  logic                 in_send;
  logic                 in_wait;
  logic                 is_stx;
  logic                 is_sta;
  logic                 is_stb;
  logic                 is_stc;
  logic [7:0]           gross_char;
  logic [7:0]           tare_char;
  logic [WSF_IDX_W-1:0] idx_next;
  logic                 fmt_take;

  // Live status bytes, captured into the snapshot at each STX
  wsf_status_encoder u_status (
    .cfg_in       (scale_cfg_in),
    .meas_in      (meas_in),
    .status_a_out (sta_now),
    .status_b_out (stb_now),
    .status_c_out (stc_now)
  );

  // Selector writes outside 0..4 are ignored, keeping the old value
  assign fmt_legal  = (fmt_data_in <= WSF_FMT_MAX);
  assign fmt_take   = fmt_wr_in && fmt_legal;
  assign continuous = (fmt_q == WSF_FMT_CONT);

  // Baud choice; unknown codes fall back to the slowest legal rate
  assign period_sel = (baud_sel_in == WSF_BAUD_2400)  ? DIV_2400 :
                      (baud_sel_in == WSF_BAUD_4800)  ? DIV_4800 :
                      (baud_sel_in == WSF_BAUD_9600)  ? DIV_9600 :
                      (baud_sel_in == WSF_BAUD_19200) ? DIV_19200 :
                      DIV_1200;

  // State decodes
  assign in_idle = (state_q == WSF_ST_IDLE);
  assign in_send = (state_q == WSF_ST_SEND);
  assign in_wait = (state_q == WSF_ST_WAIT);

  // Sequencing decodes; a frame only starts on an idle transmitter
  assign at_last     = (idx_q == WSF_IDX_CR);
  assign idx_next    = idx_q + 1'b1;
  assign tx_valid    = in_send;
  assign begin_frame = continuous && tx_ready &&
                       (in_idle || (in_wait && at_last));

  // Digit selection, most significant digit first
  assign in_gross    = (idx_q >= WSF_IDX_GROSS) && (idx_q < WSF_IDX_TARE);
  assign in_tare     = (idx_q >= WSF_IDX_TARE) && (idx_q < WSF_IDX_CR);
  assign gross_ofs   = idx_q - WSF_IDX_GROSS;
  assign tare_ofs    = idx_q - WSF_IDX_TARE;
  assign gross_digit = gross_q[WSF_DIGIT_MSD - gross_ofs[2:0]];
  assign tare_digit  = tare_q[WSF_DIGIT_MSD - tare_ofs[2:0]];

  // Field decodes for the character multiplexer
  assign is_stx = (idx_q == WSF_IDX_STX);
  assign is_sta = (idx_q == WSF_IDX_STA);
  assign is_stb = (idx_q == WSF_IDX_STB);
  assign is_stc = (idx_q == WSF_IDX_STC);

  // Digits go out as ASCII; a non-BCD nibble is not screened
  assign gross_char = WSF_ASCII_ZERO | {4'h0, gross_digit};
  assign tare_char  = WSF_ASCII_ZERO | {4'h0, tare_digit};

  // Character for the current position in the telegram
  assign tx_byte = is_stx   ? WSF_ASCII_STX :
                   is_sta   ? sta_q :
                   is_stb   ? stb_q :
                   is_stc   ? stc_q :
                   in_gross ? gross_char :
                   in_tare  ? tare_char :
                   WSF_ASCII_CR;

  // Next state and index
  always_comb
  begin
    // Hold by default
    state_d = state_q;
    idx_d   = idx_q;
    unique case (state_q)
      WSF_ST_IDLE:
      begin
        if (begin_frame)
        begin
          state_d = WSF_ST_SEND;
          idx_d   = WSF_IDX_STX;
        end
      end

      // Hold the character until the transmitter takes it
      WSF_ST_SEND:
      begin
        if (tx_ready)
        begin
          state_d = WSF_ST_WAIT;
        end
      end

      // A finished CR chains straight into the next STX when allowed
      WSF_ST_WAIT:
      begin
        if (begin_frame)
        begin
          state_d = WSF_ST_SEND;
          idx_d   = WSF_IDX_STX;
        end
        else if (tx_ready && at_last)
        begin
          state_d = WSF_ST_IDLE;
        end
        else if (tx_ready)
        begin
          state_d = WSF_ST_SEND;
          idx_d   = idx_next;
        end
      end

      // Unused state code recovers to idle
      default:
      begin
        state_d = WSF_ST_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= WSF_ST_IDLE;
      idx_q   <= WSF_IDX_STX;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  // Format selector and start pulse; the pulse rises on the capture edge, one cycle after begin_frame
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      fmt_q   <= WSF_FMT_RESET;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= begin_frame;
      if (fmt_take)
      begin
        fmt_q <= fmt_data_in;
      end
    end
  end

  // One coherent snapshot per telegram; bytes cannot mix two measurements
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      sta_q    <= '0;
      stb_q    <= '0;
      stc_q    <= '0;
    end
    else if (begin_frame)
    begin
      sta_q    <= sta_now;
      stb_q    <= stb_now;
      stc_q    <= stc_now;
    end
  end

  // Digits and bit period share the capture edge of the status bytes
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      gross_q  <= '0;
      tare_q   <= '0;
      period_q <= '0;
    end
    else if (begin_frame)
    begin
      gross_q  <= gross_bcd_in;
      tare_q   <= tare_bcd_in;
      period_q <= period_sel;
    end
  end

  // Serial character engine
  // The period comes from the snapshot, so a baud change waits for the next STX
  wsf_uart_tx u_tx (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .valid_in      (tx_valid),
    .data_in       (tx_byte),
    .bit_cycles_in (period_q),
    .ready_out     (tx_ready),
    .txd_out       (txd_out)
  );

  // Selector and framer outputs
  assign output_format_selector_out = fmt_q;
  assign telegram_active_out        = !in_idle;
  assign telegram_start_out         = start_q;

  // Snapshot outputs stand until the next STX
  assign status_byte_first_out      = sta_q;
  assign status_byte_second_out     = stb_q;
  assign status_byte_third_out      = stc_q;

endmodule : wsf_frame_encoder

/* verification/wsf_frame_encoder_checker.sv */
// Port checker for the weight status frame encoder.
// Assumes one clock and a synchronous active-low reset; bound to the top.
`timescale 1ns/10ps
module wsf_frame_encoder_checker
  import wsf_pkg::*;
(
  // Clock, reset and selector write
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       fmt_wr_in,
  input  wire logic [2:0] fmt_data_in,
  // Observed outputs
  input  wire logic [2:0] output_format_selector_out,
  input  wire logic       telegram_active_out,
  input  wire logic       telegram_start_out,
  input  wire logic [7:0] status_byte_first_out,
  input  wire logic [7:0] status_byte_second_out,
  input  wire logic [7:0] status_byte_third_out,
  input  wire logic       txd_out
);
  // Whole block sits in one clock domain
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  AST_SEL_TAKE: assert property (
    fmt_wr_in && fmt_data_in <= WSF_FMT_MAX |=> output_format_selector_out == $past(fmt_data_in))
    else $error("selector did not take a legal write");
  AST_SEL_HOLD: assert property (
    !fmt_wr_in || fmt_data_in > WSF_FMT_MAX |=> $stable(output_format_selector_out))
    else $error("selector changed without a legal write");
  AST_CONT_ONLY: assert property (
    telegram_start_out |-> $past(output_format_selector_out) == WSF_FMT_CONT)
    else $error("telegram started outside continuous format");
  AST_STX_FIRST: assert property (telegram_start_out |=> !txd_out)
    else $error("start bit did not follow telegram start");
  AST_IDLE_HIGH: assert property (!telegram_active_out |-> txd_out)
    else $error("serial line not high while idle");
  AST_STA_FIXED: assert property (
    telegram_start_out |-> status_byte_first_out[7:5] == 3'h3)
    else $error("first status byte fixed bits wrong");
  AST_STA_CODES: assert property (
    telegram_start_out |-> !(status_byte_first_out[2:0] inside {3'h1, 3'h2}) &&
      status_byte_first_out[4:3] != 2'h0)
    else $error("reserved code in first status byte");
  AST_STB_FIXED: assert property (
    telegram_start_out |-> status_byte_second_out[7] == 1'b0 && status_byte_second_out[5])
    else $error("second status byte fixed bits wrong");
  AST_STC_ONES: assert property (telegram_start_out |-> status_byte_third_out == 8'hFF)
    else $error("third status byte not all ones");
  AST_SNAP_HOLD: assert property (
    telegram_start_out |=> ($stable(status_byte_first_out) && $stable(status_byte_second_out))[*8])
    else $error("status snapshot changed inside a telegram");

  // Main scenarios reached
  COV_START: cover property (telegram_start_out);
  COV_REFUSE: cover property (fmt_wr_in && fmt_data_in > WSF_FMT_MAX);
  COV_FALLBACK: cover property (telegram_start_out && status_byte_first_out == 8'h68);
endmodule : wsf_frame_encoder_checker

bind wsf_frame_encoder wsf_frame_encoder_checker i_chk (
  .clk_in, .reset_n_in, .fmt_wr_in, .fmt_data_in, .output_format_selector_out,
  .telegram_active_out, .telegram_start_out, .status_byte_first_out,
  .status_byte_second_out, .status_byte_third_out, .txd_out);

/* verification/wsf_serial_rx_model.sv */
// Remote receiver model: decodes characters from the serial line.
// Assumes the bench sets the bit period in clock cycles before each telegram.
`timescale 1ns/10ps
module wsf_serial_rx_model
(
  // Clock and line
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        rxd_in,
  input  wire logic [15:0] bit_cycles_in,
  // Received characters
  output logic [7:0]       rx_byte_out,
  output logic             rx_stb_out,
  output logic             rx_err_out
);
  int         k;
  logic [7:0] sh;

  initial
  begin
    rx_byte_out = 8'h00;
    rx_stb_out  = 1'b0;
    rx_err_out  = 1'b0;
  end

  // Sample mid-bit on falling clock so the registered line has settled
  always
  begin
    @(negedge rxd_in);
    if (reset_n_in === 1'b1)
    begin
      repeat (bit_cycles_in >> 1) @(negedge clk_in);
      if (rxd_in !== 1'b0) rx_err_out = 1'b1;
      for (k = 0; k < 8; k++)
      begin
        repeat (bit_cycles_in) @(negedge clk_in);
        sh[k] = rxd_in;
      end
      repeat (bit_cycles_in) @(negedge clk_in);
      if (rxd_in !== 1'b1) rx_err_out = 1'b1;
      @(posedge clk_in);
      rx_byte_out <= sh;
      rx_stb_out  <= 1'b1;
      @(posedge clk_in);
      rx_stb_out  <= 1'b0;
    end
  end
endmodule : wsf_serial_rx_model

/* verification/wsf_frame_encoder_bench.sv */
// Self-checking bench for the weight status frame encoder.
// Assumes a shortened CLK_HZ so each bit lasts only 2 to 40 clock cycles.
`timescale 1ns/10ps
module wsf_frame_encoder_bench;
  import wsf_pkg::*;
  localparam int CLK_HZ = 48000;  // 40 cycles a bit at 1200, 2 at 19200
  // Design ports
  logic           clk_in = 1'b0;
  logic           reset_n_in = 1'b0;
  wsf_meas_s      meas_in = '0;
  wsf_scale_cfg_s scale_cfg_in = '0;
  wsf_digits_t    gross_bcd_in = '0;
  wsf_digits_t    tare_bcd_in = '0;
  wsf_baud_e      baud_sel_in = WSF_BAUD_19200;
  logic           fmt_wr_in = 1'b0;
  logic [2:0]     fmt_data_in = 3'h0;
  logic [2:0]     output_format_selector_out;
  logic           telegram_active_out, telegram_start_out, txd_out;
  logic [7:0]     status_byte_first_out, status_byte_second_out, status_byte_third_out;
  // Receiver and expectations
  logic [15:0]    rx_period = 16'h0002;
  logic [7:0]     rx_byte;
  logic           rx_stb, rx_err;
  int             fails = 0;
  int             n_compared = 0;
  int             rates[5] = '{1200, 2400, 4800, 9600, 19200};
  logic [7:0]     exp_a, exp_b, nxt_a, nxt_b;
  wsf_digits_t    exp_g, exp_t, nxt_g, nxt_t;
  logic [15:0]    exp_p, nxt_p;

  wsf_frame_encoder #(.CLK_HZ(CLK_HZ)) i_dut (.clk_in, .reset_n_in, .meas_in, .scale_cfg_in,
    .gross_bcd_in, .tare_bcd_in, .baud_sel_in, .fmt_wr_in, .fmt_data_in,
    .output_format_selector_out, .telegram_active_out, .telegram_start_out,
    .status_byte_first_out, .status_byte_second_out, .status_byte_third_out, .txd_out);
  wsf_serial_rx_model i_rx (.clk_in, .reset_n_in, .rxd_in(txd_out), .bit_cycles_in(rx_period),
    .rx_byte_out(rx_byte), .rx_stb_out(rx_stb), .rx_err_out(rx_err));

  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want)
    begin
      fails++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check

  // Reserved decimal or step settings fall back on both fields
  function automatic logic [7:0] exp_first(input int d, input int s);
    if (d > 5 || s > 2) return 8'h68;
    return {3'h3, 2'(s + 1), (d == 0) ? 3'h0 : 3'(d + 2)};
  endfunction : exp_first

  task automatic wr_fmt(input logic [2:0] v);
    @(negedge clk_in);
    fmt_wr_in   = 1'b1;
    fmt_data_in = v;
    @(negedge clk_in);
    fmt_wr_in   = 1'b0;
  endtask : wr_fmt

  // Drive measurement set i and work out what its telegram must carry
  task automatic apply(input int i);
    int j;
    scale_cfg_in.dec  = wsf_dec_e'(3'(i % 8));
    scale_cfg_in.step = 2'(i % 4);
    meas_in = (i < 6) ? wsf_meas_s'(6'h01 << i) : wsf_meas_s'(6'(i * 7));
    baud_sel_in = wsf_baud_e'(3'(i % 5));
    for (j = 0; j < WSF_DIGITS; j++)
    begin
      gross_bcd_in[j] = 4'((i + j) % 10);
      tare_bcd_in[j]  = 4'((i + 9 - j) % 10);
    end
    nxt_a = exp_first(i % 8, i % 4);
    nxt_b = {1'b0, meas_in.pu_zeroed, 1'b1, meas_in.kg, meas_in.motion, meas_in.overload,
             meas_in.negative, meas_in.net};
    nxt_g = gross_bcd_in;
    nxt_t = tare_bcd_in;
    nxt_p = 16'(CLK_HZ / rates[i % 5]);
  endtask : apply

  task automatic promote();
    exp_a = nxt_a;
    exp_b = nxt_b;
    exp_g = nxt_g;
    exp_t = nxt_t;
    exp_p = nxt_p;
  endtask : promote

  task automatic wait_start();
    int w;
    w = 0;
    do
    begin
      @(negedge clk_in);
      w++;
    end
    while (telegram_start_out !== 1'b1 && w < 200);
    check({7'h00, telegram_start_out}, 8'h01);
    check(status_byte_first_out, exp_a);
    check(status_byte_second_out, exp_b);
    check(status_byte_third_out, 8'hFF);
    rx_period = exp_p;
  endtask : wait_start

  // Inputs already changed mid-telegram must not leak into these bytes
  task automatic collect();
    int         k, w;
    logic [7:0] want;
    for (k = 0; k < 19; k++)
    begin
      w = 0;
      do
      begin
        @(negedge clk_in);
        w++;
      end
      while (rx_stb !== 1'b1 && w < 1000);
      if (k == 0) want = 8'h02;
      else if (k == 1) want = exp_a;
      else if (k == 2) want = exp_b;
      else if (k == 3) want = 8'hFF;
      else if (k < 11) want = {4'h3, exp_g[10 - k]};
      else if (k < 18) want = {4'h3, exp_t[17 - k]};
      else want = 8'h0D;
      check(rx_byte, want);
    end
  endtask : collect

  // Selector resets to 2, takes 0..4, ignores 5..7, sends nothing unless 4
  task automatic test_selector();
    logic [2:0] want;
    int         v;
    want = 3'h2;
    check({5'h00, output_format_selector_out}, {5'h00, want});
    for (v = 0; v < 8; v++)
    begin
      if (v != 4)
      begin
        wr_fmt(3'(v));
        if (v < 5) want = 3'(v);
        check({5'h00, output_format_selector_out}, {5'h00, want});
        check({6'h00, telegram_active_out, txd_out}, 8'h01);
      end
    end
    apply(0);
    promote();
    wr_fmt(3'h4);
    check({5'h00, output_format_selector_out}, 8'h04);
  endtask : test_selector

  // Back-to-back telegrams over every decimal, step, flag and rate
  task automatic test_frames();
    int i;
    for (i = 1; i < 11; i++)
    begin
      wait_start();
      apply(i);
      collect();
      promote();
    end
  endtask : test_frames

  // Leaving format 4 mid-telegram finishes it, then the line stays idle
  task automatic test_stop();
    wait_start();
    wr_fmt(3'h2);
    collect();
    repeat (exp_p + 2) @(negedge clk_in);  // Let the CR stop bit finish
    repeat (300)
    begin
      @(negedge clk_in);
      check({6'h00, telegram_active_out, txd_out}, 8'h01);
    end
    check({7'h00, rx_err}, 8'h00);
  endtask : test_stop

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // Main sequence after three reset cycles
  initial
  begin
    repeat (3) @(negedge clk_in);
    reset_n_in = 1'b1;
    test_selector();
    test_frames();
    test_stop();
    test_done();
  end

  // Watchdog well beyond the longest expected run
  initial
  begin
    repeat (80000) @(posedge clk_in);
    fails++;
    test_done();
  end
endmodule : wsf_frame_encoder_bench
